// >>> logic/pad_map.svh
// register map, field positions, reset values and timing counts
`ifndef PAD_MAP_SVH
`define PAD_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PAD_OFS_OBS_DIV    12'h000
`define PAD_OFS_BYP_DIV    12'h004
`define PAD_OFS_GO_CMD     12'h008
`define PAD_OFS_STATUS     12'h00C

// ----------------------------------------
// field positions
// ----------------------------------------
`define PAD_RATIO_MSB      4
`define PAD_RATIO_LSB      0
`define PAD_DIV_EN_BIT     15
`define PAD_GO_BIT         0
`define PAD_STAT_GO_BIT    0
`define PAD_STAT_STBL_BIT  2

// ----------------------------------------
// reset values
// ----------------------------------------
`define PAD_RST_DIV_EN     1'b1
`define PAD_RST_OBS_RATIO  5'h00
`define PAD_RST_BYP_RATIO0 5'h00
`define PAD_RST_BYP_RATIO1 5'h01

// ----------------------------------------
// timing
// ----------------------------------------
`define PAD_CLK_PERIOD_NS  10
`define PAD_OSC_STABLE_NS  2560
`define PAD_OSC_STABLE_CYC ((`PAD_OSC_STABLE_NS + `PAD_CLK_PERIOD_NS - 1) / `PAD_CLK_PERIOD_NS)

`endif

// >>> logic/pad_pkg.sv
// types shared by the auxiliary divider block
package pad_pkg;

  // ----------------------------------------
  // go sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PAD_GO_IDLE,
    PAD_GO_ISSUE,
    PAD_GO_WAIT
  } pad_go_state_t;

  // ----------------------------------------
  // controller instance
  // ----------------------------------------
  typedef enum logic {
    PAD_INST_FIRST,
    PAD_INST_SECOND
  } pad_inst_t;

endpackage : pad_pkg

// >>> logic/pad_clkdiv.sv
// programmable divider producing a one-cycle clock enable pulse
`timescale 1ns/1ns
module pad_clkdiv #(
  parameter int RATIO_W = 5
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // control
  input  wire logic               div_en,
  input  wire logic [RATIO_W-1:0] ratio,
  // divided enable
  output logic                    tick
);

  logic [RATIO_W-1:0] cnt_ff;
  logic [RATIO_W-1:0] nxt_cnt;
  logic               tick_ff;
  logic               nxt_tick;
  wire                at_end = (cnt_ff >= ratio);

  // ----------------------------------------
  // counter wraps after ratio plus one cycles
  // ----------------------------------------
  assign nxt_cnt  = (!div_en || at_end) ? '0 : cnt_ff + 1'b1;
  assign nxt_tick = div_en && at_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : pad_clkdiv

// >>> logic/pad_ctrl.sv
// auxiliary dividers, go command and status registers on apb
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "pad_map.svh"
module pad_ctrl #(
  parameter pad_pkg::pad_inst_t INSTANCE        = pad_pkg::PAD_INST_FIRST,
  parameter int                 RATIO_W         = 5,
  parameter int                 OSC_STABLE_CYC  = `PAD_OSC_STABLE_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // gate from the clock enable register
  input  wire logic        observation_output_enable,
  // observation clock enable (first clock output pin)
  output logic             observation_clock,
  // bypass system clock enable
  output logic             bypass_system_clock,
  // go link to the system clock dividers
  output logic             go_request,
  input  wire logic        go_done,
  // oscillator stable flag
  output logic             osc_stable
);

  // ----------------------------------------
  // instance selection
  // ----------------------------------------
  localparam logic HAS_OBS = (INSTANCE == pad_pkg::PAD_INST_FIRST);
  localparam logic [RATIO_W-1:0] BYP_RATIO_RST =
    HAS_OBS ? RATIO_W'(`PAD_RST_BYP_RATIO0) : RATIO_W'(`PAD_RST_BYP_RATIO1);
  localparam int CNT_W = $clog2(OSC_STABLE_CYC + 1);
  localparam logic [CNT_W-1:0] STABLE_LAST = CNT_W'(OSC_STABLE_CYC);

  // ----------------------------------------
  // divider word packing
  // ----------------------------------------
  function automatic logic [31:0] pad_div_word(input logic en,
                                               input logic [RATIO_W-1:0] ratio);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`PAD_DIV_EN_BIT] = en;
    w[RATIO_W-1:0] = ratio;
    return w;
  endfunction : pad_div_word

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_acc    = access_ph && pwrite;
  wire hit_obs   = (paddr == `PAD_OFS_OBS_DIV);
  wire hit_byp   = (paddr == `PAD_OFS_BYP_DIV);
  wire hit_go    = (paddr == `PAD_OFS_GO_CMD);
  wire hit_stat  = (paddr == `PAD_OFS_STATUS);
  wire mapped    = hit_obs || hit_byp || hit_go || hit_stat;
  wire wr_obs    = wr_acc && hit_obs && HAS_OBS;
  wire wr_byp    = wr_acc && hit_byp;
  wire go_wr_one = wr_acc && hit_go && pwdata[`PAD_GO_BIT];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic                  obs_en_ff;
  logic [RATIO_W-1:0]    obs_ratio_ff;
  logic                  byp_en_ff;
  logic [RATIO_W-1:0]    byp_ratio_ff;
  logic [31:0]           prdata_ff;
  logic                  pslverr_ff;
  logic [CNT_W-1:0]      osc_cnt_ff;
  logic                  stable_ff;
  logic                  go_req_ff;
  pad_pkg::pad_go_state_t go_state_ff;

  logic                  nxt_obs_en;
  logic [RATIO_W-1:0]    nxt_obs_ratio;
  logic                  nxt_byp_en;
  logic [RATIO_W-1:0]    nxt_byp_ratio;
  logic [31:0]           nxt_prdata;
  logic                  nxt_pslverr;
  logic [CNT_W-1:0]      nxt_osc_cnt;
  logic                  nxt_stable;
  logic                  nxt_go_req;
  pad_pkg::pad_go_state_t nxt_go_state;

  // ----------------------------------------
  // divider register next values
  // ----------------------------------------
  // obs and byp enable and ratio fields
  assign nxt_obs_en    = wr_obs ? pwdata[`PAD_DIV_EN_BIT] : obs_en_ff;
  assign nxt_obs_ratio = wr_obs ? pwdata[RATIO_W-1:0] : obs_ratio_ff;
  assign nxt_byp_en    = wr_byp ? pwdata[`PAD_DIV_EN_BIT] : byp_en_ff;
  assign nxt_byp_ratio = wr_byp ? pwdata[RATIO_W-1:0] : byp_ratio_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obs_en_ff    <= `PAD_RST_DIV_EN;
      obs_ratio_ff <= RATIO_W'(`PAD_RST_OBS_RATIO);
      byp_en_ff    <= `PAD_RST_DIV_EN;
      byp_ratio_ff <= BYP_RATIO_RST;
    end else begin
      obs_en_ff    <= nxt_obs_en;
      obs_ratio_ff <= nxt_obs_ratio;
      byp_en_ff    <= nxt_byp_en;
      byp_ratio_ff <= nxt_byp_ratio;
    end
  end

  // ----------------------------------------
  // go sequencer
  // ----------------------------------------
  always_comb begin
    nxt_go_state = go_state_ff;
    nxt_go_req   = 1'b0;
    case (go_state_ff)
      pad_pkg::PAD_GO_IDLE: begin
        if (go_wr_one) begin
          nxt_go_state = pad_pkg::PAD_GO_ISSUE;
          nxt_go_req   = 1'b1;
        end
      end
      pad_pkg::PAD_GO_ISSUE: begin
        nxt_go_state = go_done ? pad_pkg::PAD_GO_IDLE : pad_pkg::PAD_GO_WAIT;
      end
      pad_pkg::PAD_GO_WAIT: begin
        if (go_done) begin
          nxt_go_state = pad_pkg::PAD_GO_IDLE;
        end
      end
      default: begin
        nxt_go_state = pad_pkg::PAD_GO_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_state_ff <= pad_pkg::PAD_GO_IDLE;
      go_req_ff   <= 1'b0;
    end else begin
      go_state_ff <= nxt_go_state;
      go_req_ff   <= nxt_go_req;
    end
  end

  wire go_busy = (go_state_ff != pad_pkg::PAD_GO_IDLE);

  // ----------------------------------------
  // oscillator stabilisation counter
  // ----------------------------------------
  // stable after count
  assign nxt_osc_cnt = stable_ff ? osc_cnt_ff : osc_cnt_ff + 1'b1;
  assign nxt_stable  = stable_ff || (osc_cnt_ff == STABLE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_ff <= '0;
      stable_ff  <= 1'b0;
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
      stable_ff  <= nxt_stable;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // reserved bits zero
  wire [31:0] rd_obs  = HAS_OBS ? pad_div_word(obs_en_ff, obs_ratio_ff) : 32'h0000_0000;
  wire [31:0] rd_byp  = pad_div_word(byp_en_ff, byp_ratio_ff);
  wire [31:0] rd_go   = 32'h0000_0000;
  wire [31:0] rd_stat = {29'h0000_0000, stable_ff, 1'b0, go_busy};
  wire [31:0] rd_mux  = hit_obs ? rd_obs :
                        hit_byp ? rd_byp :
                        hit_go  ? rd_go  :
                        hit_stat ? rd_stat : 32'h0000_0000;

  assign nxt_prdata  = (setup_ph && !pwrite) ? rd_mux : prdata_ff;
  assign nxt_pslverr = setup_ph ? !mapped : pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = access_ph && pslverr_ff;

  // ----------------------------------------
  // dividers
  // ----------------------------------------
  logic obs_tick;
  logic byp_tick;

  wire obs_run = HAS_OBS && obs_en_ff && observation_output_enable;

  pad_clkdiv #(
    .RATIO_W (RATIO_W)
  ) u_obs_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div_en  (obs_run),
    .ratio   (obs_ratio_ff),
    .tick    (obs_tick)
  );

  pad_clkdiv #(
    .RATIO_W (RATIO_W)
  ) u_byp_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div_en  (byp_en_ff),
    .ratio   (byp_ratio_ff),
    .tick    (byp_tick)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign observation_clock   = obs_tick;
  assign bypass_system_clock = byp_tick;
  assign go_request          = go_req_ff;
  assign osc_stable          = stable_ff;

endmodule : pad_ctrl

// >>> tb/pad_ctrl_asserts.sv
// concurrent checks on the auxiliary divider block ports
`timescale 1ns/1ns
module pad_chk #(
  parameter int OSC_STABLE_CYC = 256
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // clocks and go link
  input wire logic        observation_output_enable,
  input wire logic        observation_clock,
  input wire logic        go_request,
  input wire logic        go_done,
  input wire logic        osc_stable
);
  logic        busy_ff;
  logic [15:0] cnt_ff;
  wire         acc    = psel && penable;
  wire         go_wr  = acc && pwrite && paddr == 12'h008;
  wire         rd_div = acc && !pwrite && (paddr == 12'h000 || paddr == 12'h004);
  wire         rd_st  = acc && !pwrite && paddr == 12'h00C;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 16'h0000;
    end else begin
      busy_ff <= (busy_ff || go_request) && !go_done;
      cnt_ff  <= (cnt_ff == 16'hFFFF) ? cnt_ff : cnt_ff + 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_go_single: assert property (go_request |=> !go_request)
    else $error("go request wider than one cycle");
  a_go_start: assert property (go_wr && pwdata[0] && !busy_ff && !go_request |=> go_request)
    else $error("go write did not start");
  a_go_zero: assert property (go_wr && !pwdata[0] |=> !go_request)
    else $error("zero write started go");
  a_go_busy: assert property (busy_ff |-> !go_request)
    else $error("go restarted while busy");
  a_div_rsvd: assert property (rd_div |-> prdata[31:16] == 16'h0000 && prdata[14:5] == 10'h000)
    else $error("divider reserved bits set");
  a_stat_bits: assert property (rd_st |-> prdata[0] == $past(busy_ff || go_request)
    && prdata[2] == $past(osc_stable) && prdata[31:3] == 29'h0 && !prdata[1])
    else $error("status read wrong");
  a_obs_gate: assert property (!observation_output_enable [*2] |-> !observation_clock)
    else $error("observation clock ran while gated");
  a_osc_time: assert property (cnt_ff == 16'(OSC_STABLE_CYC + 1) |-> $rose(osc_stable))
    else $error("stable flag timing wrong");
  a_osc_hold: assert property (osc_stable |=> osc_stable)
    else $error("stable flag dropped");
endmodule : pad_chk

bind pad_ctrl pad_chk #(.OSC_STABLE_CYC(OSC_STABLE_CYC)) i_pad_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .observation_output_enable(observation_output_enable),
  .observation_clock(observation_clock), .go_request(go_request), .go_done(go_done),
  .osc_stable(osc_stable));

// >>> tb/pad_ctrl_tb.sv
// self-checking bench for the auxiliary divider block
`timescale 1ns/1ns
module pad_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, obs_gate, go_done;
  logic        pready, pslverr, obs_clk, byp_clk, go_req, stable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata2, d;
  logic [31:0] q1[$], q2[$];
  logic [4:0]  ro, rb;
  int          fails, compares, cyc, no, nb, ng;

  pad_ctrl #(.OSC_STABLE_CYC(4)) i_pad_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .observation_output_enable(obs_gate), .observation_clock(obs_clk),
    .bypass_system_clock(byp_clk), .go_request(go_req), .go_done(go_done),
    .osc_stable(stable));
  pad_ctrl #(.INSTANCE(pad_pkg::PAD_INST_SECOND), .OSC_STABLE_CYC(4)) i_pad_ctrl_second (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata2), .pslverr(),
    .observation_output_enable(obs_gate), .observation_clock(),
    .bypass_system_clock(), .go_request(), .go_done(go_done), .osc_stable());

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic print_verdict();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(logic [11:0] a, logic [31:0] e1, logic [31:0] e2);
    q1.push_back(e1);
    q2.push_back(e2);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic tally(int n);
    no = 0;
    nb = 0;
    repeat (n) begin
      @(posedge pclk);
      no += obs_clk;
      nb += byp_clk;
    end
  endtask : tally

  // ----------------------------------------
  // read scoreboard and cycle limit
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (go_req === 1'b1) ng++;
    if (psel && penable && pready) begin
      chk("pslverr", pslverr, !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}));
      if (!pwrite) begin
        chk("prdata", prdata, q1.pop_front());
        chk("prdata second", prdata2, q2.pop_front());
      end
    end
    if (cyc > 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, obs_gate, go_done} = '0;
    presetn = 1'b0;
    d = $urandom(39);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h0000_8000, 32'h0000_0000);
    rd(12'h004, 32'h0000_8000, 32'h0000_8001);
    rd(12'h008, 32'h0000_0000, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0004, 32'h0000_0004);
    chk("osc stable", stable, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0000_801F, 32'h0000_0000);
    d = $urandom;
    apb(1'b1, 12'h004, d);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    rd(12'h004, d & 32'h0000_801F, d & 32'h0000_801F);
    obs_gate <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ro = (i == 3) ? 5'h1F : ((i < 2) ? 5'(i) : 5'($urandom));
      rb = (i == 3) ? 5'h1F : 5'($urandom);
      apb(1'b1, 12'h000, {16'h0000, 1'b1, 10'h000, ro});
      apb(1'b1, 12'h004, {16'h0000, 1'b1, 10'h000, rb});
      tally(70);
      tally(4 * (ro + 1));
      chk("obs ticks", no, 4);
      tally(4 * (rb + 1));
      chk("byp ticks", nb, 4);
    end
    obs_gate <= 1'b0;
    tally(3);
    tally(70);
    chk("obs gated", no, 0);
    obs_gate <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0000);
    tally(3);
    tally(40);
    chk("obs off", no, 0);
    chk("byp off", nb, 0);
    apb(1'b1, 12'h008, 32'h0000_0000);
    tally(10);
    chk("go on zero", ng, 0);
    apb(1'b1, 12'h008, 32'h0000_0001);
    rd(12'h00C, 32'h0000_0005, 32'h0000_0005);
    go_done <= 1'b1;
    @(posedge pclk);
    go_done <= 1'b0;
    @(posedge pclk);
    rd(12'h00C, 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, 12'h008, 32'h0000_0001);
    rd(12'h00C, 32'h0000_0005, 32'h0000_0005);
    chk("go pulses", ng, 2);
    print_verdict();
  end
endmodule : pad_ctrl_tb
